// ==== design/rtc_pkg.sv ====
package rtc_pkg;
    localparam logic [3:0] A_SEC = 4'h0;
    localparam logic [3:0] A_MIN = 4'h1;
    localparam logic [3:0] A_HOUR = 4'h2;
    localparam logic [3:0] A_WDAY = 4'h3;
    localparam logic [3:0] A_MDAY = 4'h4;
    localparam logic [3:0] A_MON = 4'h5;
    localparam logic [3:0] A_YEAR = 4'h6;
    localparam logic [3:0] A_TRIM = 4'h7;
    localparam logic [3:0] A_WAMIN = 4'h8;
    localparam logic [3:0] A_WAHR = 4'h9;
    localparam logic [3:0] A_WADAY = 4'ha;
    localparam logic [3:0] A_DAMIN = 4'hb;
    localparam logic [3:0] A_DAHR = 4'hc;
    localparam logic [3:0] A_USER = 4'hd;
    localparam logic [3:0] A_CTL1 = 4'he;
    localparam logic [3:0] A_CTL2 = 4'hf;
    // Writable bit masks; unused bits never store and read zero
    localparam logic [7:0] M_SEC = 8'h7f;
    localparam logic [7:0] M_HOUR = 8'h3f;
    localparam logic [7:0] M_WDAY = 8'h07;
    localparam logic [7:0] M_MDAY = 8'h3f;
    localparam logic [7:0] M_MON = 8'h1f;
    localparam logic [7:0] M_WADAY = 8'h7f;
    localparam logic [7:0] CTL2_RST = 8'h70;
    // Control one fields
    localparam int C1_WEEKLY_ALARM_ENABLE = 7;
    localparam int C1_DAILY_ALARM_ENABLE = 6;
    localparam int C1_H24 = 5;
    localparam int C1_BSW = 4;
    // Control two fields
    localparam int C2_SPA = 7;
    localparam int C2_LOW = 6;
    localparam int C2_HALT = 5;
    localparam int C2_PON = 4;
    localparam int C2_SPB = 3;
    localparam int C2_PFG = 2;
    localparam int C2_WFG = 1;
    localparam int C2_DFG = 0;
    localparam int TRIM_DEV = 7;
    // BCD landmarks of the time counters
    localparam logic [7:0] H_AM12 = 8'h12;
    localparam logic [7:0] H_AM11 = 8'h11;
    localparam logic [7:0] H_PM12 = 8'h32;
    localparam logic [7:0] H_PM1 = 8'h21;
    localparam logic [7:0] H_PM11 = 8'h31;
    localparam logic [7:0] H_23 = 8'h23;
    localparam logic [7:0] B_59 = 8'h59;
    localparam logic [7:0] B_99 = 8'h99;
    localparam logic [7:0] B_ONE = 8'h01;
    localparam logic [7:0] B_ZERO = 8'h00;
    localparam logic [7:0] B_DEC = 8'h12;
    localparam logic [7:0] B_SAT = 8'h06;
    localparam logic [7:0] B_TRIMCO = 8'h20;
    // Clock and timing
    localparam int CLK_HZ = 40000000;
    localparam int SEC_HZ = 1;
    localparam int SEC_CYC = CLK_HZ / SEC_HZ;
    localparam int TRIM_STEP_CYC = 120;
    // Periodic select codes
    localparam logic [2:0] P_HIGH = 3'h0;
    localparam logic [2:0] P_LOW = 3'h1;
    localparam logic [2:0] P_2HZ = 3'h2;
    localparam logic [2:0] P_1HZ = 3'h3;
    localparam logic [2:0] P_SEC = 3'h4;
    localparam logic [2:0] P_MIN = 3'h5;
    localparam logic [2:0] P_HR = 3'h6;
    localparam logic [2:0] P_MON = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int RD_BIT = 3;
endpackage

// ==== design/rtc_link.sv ====
`timescale 1ns/1ps
// Serial engine on the link clock. Frame ends reset it through ce.
module rtc_link (
    // Link pins
    input wire logic sclk,
    input wire logic ce,
    input wire logic rst_n,
    input wire logic sdl_in,
    output logic sdl_out,
    output logic sdl_oe,
    // Toward the core clock domain
    output logic wr_tog_r,
    output logic [3:0] wr_addr_r,
    output logic [7:0] wr_data_r,
    output logic rd_tog_r,
    output logic [3:0] rd_addr_r,
    input wire logic [7:0] rd_data,
    input wire logic rd_ack_tog
);
    typedef enum logic [1:0] {PH_CMD, PH_TURN, PH_DATA} rtc_ph_t;
    rtc_ph_t ph_r;
    logic [2:0] cnt_r;
    logic [6:0] sh_r;
    logic [3:0] addr_r;
    logic rd_r;
    logic [7:0] so_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic frm_rst_n;
    logic [7:0] byte_in;

    assign frm_rst_n = rst_n & ce; // [R18]
    assign byte_in = {sh_r, sdl_in};
    assign sdl_out = so_r[7];

    always_ff @(posedge sclk or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            cnt_r <= 3'h0;
            sh_r <= 7'h00;
            ph_r <= PH_CMD;
            addr_r <= 4'h0;
            rd_r <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            sh_r <= byte_in[6:0];
            if (cnt_r == rtc_pkg::BIT_LAST) begin
                unique case (ph_r)
                    PH_CMD: begin
                        addr_r <= byte_in[7:4];
                        rd_r <= byte_in[rtc_pkg::RD_BIT];
                        ph_r <= byte_in[rtc_pkg::RD_BIT] ? PH_TURN : PH_DATA;
                    end
                    PH_TURN: ph_r <= PH_DATA;
                    PH_DATA: if (!rd_r) addr_r <= addr_r + 4'h1;
                endcase
            end else if (cnt_r == 3'h0 && ph_r == PH_DATA && rd_r) begin
                addr_r <= addr_r + 4'h1;
            end
        end
    end

    // Toggles survive frame ends so the core never sees a false event
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_tog_r <= 1'b0;
            wr_addr_r <= 4'h0;
            wr_data_r <= 8'h00;
        end else if (ce && cnt_r == rtc_pkg::BIT_LAST && ph_r == PH_DATA && !rd_r) begin
            wr_addr_r <= addr_r;
            wr_data_r <= byte_in;
            wr_tog_r <= ~wr_tog_r; // [R1]
        end
    end

    // Prefetch: next byte is asked for a whole byte before it is shifted
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_tog_r <= 1'b0;
            rd_addr_r <= 4'h0;
        end else if (ce && cnt_r == rtc_pkg::BIT_LAST && ph_r == PH_CMD
                     && byte_in[rtc_pkg::RD_BIT]) begin
            rd_addr_r <= byte_in[7:4];
            rd_tog_r <= ~rd_tog_r; // [R1]
        end else if (ce && cnt_r == 3'h0 && ph_r == PH_DATA && rd_r) begin
            rd_addr_r <= addr_r + 4'h1;
            rd_tog_r <= ~rd_tog_r;
        end
    end

    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= rd_ack_tog;
            ack_s2_r <= ack_s1_r;
        end
    end

    always_ff @(negedge sclk or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            so_r <= 8'h00;
            sdl_oe <= 1'b0;
        end else if (cnt_r == 3'h0 && ph_r == PH_DATA && rd_r) begin
            // A late answer shifts out zero rather than stale data
            so_r <= (ack_s2_r == rd_tog_r) ? rd_data : 8'h00;
            sdl_oe <= 1'b1;
        end else begin
            so_r <= {so_r[6:0], 1'b0};
        end
    end
endmodule // rtc_link

// ==== design/rtc_core.sv ====
`timescale 1ns/1ps
// Function
// [R1] Sixteen byte registers, all readable and writable
// [R2] Unused bits ignore writes, read zero
// [R3] Power-up defaults: trim, user, control one zero
// [R4] Power-up flag clears trim and control bits
// [R5] Trim top bit picks step size
// [R6] Control one bit four drives backup switch
// [R7] Control bit zero keeps backup path closed
// [R8] Control bit one opens backup path above threshold
// [R9] Charge path follows supply threshold
// [R10] Host leaves backup control zero normally
// [R11] Alarm enables gate alarms, default zero
// [R12] Hour format bit selects 12 or 24
// [R13] Twelve hour encoding with afternoon bit
// [R14] Host sets hour format before time
// [R15] Periodic select drives interrupt output
// [R16] Power-up flag cleared only by zero
// [R17] Year multiple of four is leap
// [R18] Host holds chip enable over access
// [R19] Counters and alarms hold packed BCD
// [R20] Alarm flags set on enabled full match
module rtc_core #(
    parameter int SEC_CYC = rtc_pkg::SEC_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    input wire logic sclk,
    input wire logic ce,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    // Supply and oscillator monitors
    input wire logic supply_above_rise,
    input wire logic supply_below_fall,
    input wire logic osc_halt_det,
    input wire logic low_supply_det,
    // Switches and interrupt
    output logic backup_path_switch,
    output logic charge_path_switch,
    output logic interrupt_out_n
);
    localparam int DIVW = $clog2(SEC_CYC + 1) + 8;
    logic [7:0] sec_r, min_r, hour_r, wday_r, mday_r, mon_r, year_r;
    logic [7:0] trim_r, wamin_r, wahr_r, waday_r, damin_r, dahr_r;
    logic [7:0] user_r, ctl1_r, ctl2_r, rd_data_r;
    logic rd_ack_r;
    logic wr_tog, rd_tog;
    logic [3:0] wr_addr, rd_addr;
    logic [7:0] wr_data;
    logic [2:0] wsy_r, rsy_r;
    logic [1:0] s_rise_r, s_fall_r, s_halt_r, s_low_r;
    logic wr_ev, rd_ev;
    logic [DIVW-1:0] div_r;
    logic [DIVW-1:0] sec_len;
    logic tick, half, min_ev, hr_ev, day_ev, mon_ev;
    logic pfg_set, wfg_set, dfg_set, per_low, min_dly_r;
    logic [2:0] psel;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4]) begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6); // [R17]
        end else begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
    endfunction

    function automatic logic [7:0] mon_last(input logic [7:0] m, input logic [7:0] y);
        unique case (m)
            8'h02: mon_last = is_leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: mon_last = 8'h30;
            default: mon_last = 8'h31;
        endcase
    endfunction

    function automatic logic [7:0] rd_mux(input logic [3:0] a);
        unique case (a)
            rtc_pkg::A_SEC: rd_mux = sec_r;
            rtc_pkg::A_MIN: rd_mux = min_r;
            rtc_pkg::A_HOUR: rd_mux = hour_r;
            rtc_pkg::A_WDAY: rd_mux = wday_r;
            rtc_pkg::A_MDAY: rd_mux = mday_r;
            rtc_pkg::A_MON: rd_mux = mon_r;
            rtc_pkg::A_YEAR: rd_mux = year_r;
            rtc_pkg::A_TRIM: rd_mux = trim_r;
            rtc_pkg::A_WAMIN: rd_mux = wamin_r;
            rtc_pkg::A_WAHR: rd_mux = wahr_r;
            rtc_pkg::A_WADAY: rd_mux = waday_r;
            rtc_pkg::A_DAMIN: rd_mux = damin_r;
            rtc_pkg::A_DAHR: rd_mux = dahr_r;
            rtc_pkg::A_USER: rd_mux = user_r;
            rtc_pkg::A_CTL1: rd_mux = ctl1_r;
            rtc_pkg::A_CTL2: rd_mux = ctl2_r;
        endcase
    endfunction

    function automatic logic wr_at(input logic [3:0] a);
        wr_at = wr_ev && wr_addr == a;
    endfunction

    rtc_link u_link (
        .sclk(sclk),
        .ce(ce),
        .rst_n(rst_n),
        .sdl_in(serial_data_line_in),
        .sdl_out(serial_data_line_out),
        .sdl_oe(serial_data_line_oe),
        .wr_tog_r(wr_tog),
        .wr_addr_r(wr_addr),
        .wr_data_r(wr_data),
        .rd_tog_r(rd_tog),
        .rd_addr_r(rd_addr),
        .rd_data(rd_data_r),
        .rd_ack_tog(rd_ack_r)
    );

    // Crossings: toggles through two flops, third flop for the edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wsy_r <= 3'h0;
            rsy_r <= 3'h0;
            s_rise_r <= 2'h0;
            s_fall_r <= 2'h0;
            s_halt_r <= 2'h0;
            s_low_r <= 2'h0;
        end else begin
            wsy_r <= {wsy_r[1:0], wr_tog};
            rsy_r <= {rsy_r[1:0], rd_tog};
            s_rise_r <= {s_rise_r[0], supply_above_rise};
            s_fall_r <= {s_fall_r[0], supply_below_fall};
            s_halt_r <= {s_halt_r[0], osc_halt_det};
            s_low_r <= {s_low_r[0], low_supply_det};
        end
    end
    assign wr_ev = wsy_r[2] ^ wsy_r[1];
    assign rd_ev = rsy_r[2] ^ rsy_r[1];

    // Read answer: address and data stay stable until the next request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 8'h00;
            rd_ack_r <= 1'b0;
        end else if (rd_ev) begin
            rd_data_r <= rd_mux(rd_addr); // [R1]
            rd_ack_r <= rsy_r[1];
        end
    end

    // Second divider; trim alters one second per 20 s or 60 s
    always_comb begin
        sec_len = DIVW'(SEC_CYC) - DIVW'(1);
        if (!ctl2_r[rtc_pkg::C2_PON] && sec_r == rtc_pkg::B_ZERO
            && (trim_r[rtc_pkg::TRIM_DEV] || 1'b1)) begin
            sec_len = DIVW'(SEC_CYC) - DIVW'(1)
                - DIVW'(signed'(trim_r[6:0])) * DIVW'(rtc_pkg::TRIM_STEP_CYC)
                  / (trim_r[rtc_pkg::TRIM_DEV] ? DIVW'(3) : DIVW'(1)); // [R5]
        end
        if (!trim_r[rtc_pkg::TRIM_DEV] && (sec_r == rtc_pkg::B_TRIMCO
            || sec_r == {rtc_pkg::B_TRIMCO[6:0], 1'b0})) begin
            sec_len = DIVW'(SEC_CYC) - DIVW'(1)
                - DIVW'(signed'(trim_r[6:0])) * DIVW'(rtc_pkg::TRIM_STEP_CYC);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
        end else if (tick || wr_at(rtc_pkg::A_SEC)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DIVW'(1);
        end
    end
    assign tick = div_r >= sec_len;
    assign half = div_r < DIVW'(SEC_CYC / 2);

    assign min_ev = tick && sec_r == rtc_pkg::B_59;
    assign hr_ev = min_ev && min_r == rtc_pkg::B_59;
    assign day_ev = hr_ev && (ctl1_r[rtc_pkg::C1_H24] ? hour_r == rtc_pkg::H_23
                              : hour_r == rtc_pkg::H_PM11);
    assign mon_ev = day_ev && mday_r == mon_last(mon_r, year_r);

    // Time counters: host write wins over counting
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_r <= 8'h00;
            min_r <= 8'h00;
        end else begin
            if (wr_at(rtc_pkg::A_SEC)) sec_r <= wr_data & rtc_pkg::M_SEC; // [R2]
            else if (tick) sec_r <= min_ev ? rtc_pkg::B_ZERO : bcd_inc(sec_r); // [R19]
            if (wr_at(rtc_pkg::A_MIN)) min_r <= wr_data & rtc_pkg::M_SEC;
            else if (min_ev) min_r <= hr_ev ? rtc_pkg::B_ZERO : bcd_inc(min_r);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hour_r <= rtc_pkg::H_AM12;
        end else if (wr_at(rtc_pkg::A_HOUR)) begin
            hour_r <= wr_data & rtc_pkg::M_HOUR;
        end else if (hr_ev) begin
            if (ctl1_r[rtc_pkg::C1_H24]) begin // [R12]
                hour_r <= (hour_r == rtc_pkg::H_23) ? rtc_pkg::B_ZERO : bcd_inc(hour_r);
            end else begin
                unique case (hour_r) // [R13]
                    rtc_pkg::H_AM12: hour_r <= rtc_pkg::B_ONE;
                    rtc_pkg::H_AM11: hour_r <= rtc_pkg::H_PM12;
                    rtc_pkg::H_PM12: hour_r <= rtc_pkg::H_PM1;
                    rtc_pkg::H_PM11: hour_r <= rtc_pkg::H_AM12;
                    default: hour_r <= bcd_inc(hour_r);
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wday_r <= 8'h00;
            mday_r <= rtc_pkg::B_ONE;
            mon_r <= rtc_pkg::B_ONE;
            year_r <= 8'h00;
        end else begin
            if (wr_at(rtc_pkg::A_WDAY)) wday_r <= wr_data & rtc_pkg::M_WDAY;
            else if (day_ev) wday_r <= (wday_r == rtc_pkg::B_SAT) ? 8'h00 : wday_r + 8'h01;
            if (wr_at(rtc_pkg::A_MDAY)) mday_r <= wr_data & rtc_pkg::M_MDAY;
            else if (day_ev) mday_r <= mon_ev ? rtc_pkg::B_ONE : bcd_inc(mday_r);
            if (wr_at(rtc_pkg::A_MON)) mon_r <= wr_data & rtc_pkg::M_MON;
            else if (mon_ev) mon_r <= (mon_r == rtc_pkg::B_DEC) ? rtc_pkg::B_ONE
                                      : bcd_inc(mon_r);
            if (wr_at(rtc_pkg::A_YEAR)) year_r <= wr_data;
            else if (mon_ev && mon_r == rtc_pkg::B_DEC)
                year_r <= (year_r == rtc_pkg::B_99) ? 8'h00 : bcd_inc(year_r);
        end
    end

    // Alarm settings and user byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wamin_r <= 8'h00;
            wahr_r <= 8'h00;
            waday_r <= 8'h00;
            damin_r <= 8'h00;
            dahr_r <= 8'h00;
            user_r <= 8'h00; // [R3]
        end else begin
            if (wr_at(rtc_pkg::A_WAMIN)) wamin_r <= wr_data & rtc_pkg::M_SEC;
            if (wr_at(rtc_pkg::A_WAHR)) wahr_r <= wr_data & rtc_pkg::M_HOUR;
            if (wr_at(rtc_pkg::A_WADAY)) waday_r <= wr_data & rtc_pkg::M_WADAY;
            if (wr_at(rtc_pkg::A_DAMIN)) damin_r <= wr_data & rtc_pkg::M_SEC;
            if (wr_at(rtc_pkg::A_DAHR)) dahr_r <= wr_data & rtc_pkg::M_HOUR;
            if (wr_at(rtc_pkg::A_USER)) user_r <= wr_data;
        end
    end

    // Power-up flag forces trim and control one to zero while set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_r <= 8'h00;
            ctl1_r <= 8'h00; // [R3] [R11] [R12]
        end else if (ctl2_r[rtc_pkg::C2_PON]) begin
            trim_r <= 8'h00; // [R4]
            ctl1_r <= 8'h00;
        end else begin
            if (wr_at(rtc_pkg::A_TRIM)) trim_r <= wr_data;
            if (wr_at(rtc_pkg::A_CTL1)) ctl1_r <= wr_data;
        end
    end

    // Alarms compare one cycle after each minute rollover, when hour and
    // weekday have already carried, so hh:00 settings match as well
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            min_dly_r <= 1'b0;
        end else begin
            min_dly_r <= min_ev;
        end
    end
    assign wfg_set = min_dly_r && ctl1_r[rtc_pkg::C1_WEEKLY_ALARM_ENABLE] // [R20] [R11]
        && min_r == wamin_r && hour_r == wahr_r && waday_r[wday_r[2:0]];
    assign dfg_set = min_dly_r && ctl1_r[rtc_pkg::C1_DAILY_ALARM_ENABLE]
        && min_r == damin_r && hour_r == dahr_r;
    assign psel = ctl1_r[2:0];
    always_comb begin
        unique case (psel)
            rtc_pkg::P_SEC: pfg_set = tick;
            rtc_pkg::P_MIN: pfg_set = min_ev;
            rtc_pkg::P_HR: pfg_set = hr_ev;
            rtc_pkg::P_MON: pfg_set = mon_ev;
            default: pfg_set = 1'b0;
        endcase
    end

    // Control two: hardware sets win over host clears
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl2_r <= rtc_pkg::CTL2_RST; // [R3]
        end else begin
            if (wr_at(rtc_pkg::A_CTL2)) begin
                ctl2_r[rtc_pkg::C2_SPA] <= wr_data[rtc_pkg::C2_SPA];
                ctl2_r[rtc_pkg::C2_SPB] <= wr_data[rtc_pkg::C2_SPB];
                if (!wr_data[rtc_pkg::C2_PON]) ctl2_r[rtc_pkg::C2_PON] <= 1'b0; // [R16]
                if (!wr_data[rtc_pkg::C2_HALT]) ctl2_r[rtc_pkg::C2_HALT] <= 1'b0;
                if (!wr_data[rtc_pkg::C2_LOW]) ctl2_r[rtc_pkg::C2_LOW] <= 1'b0;
                if (!wr_data[rtc_pkg::C2_PFG]) ctl2_r[rtc_pkg::C2_PFG] <= 1'b0;
                if (!wr_data[rtc_pkg::C2_WFG]) ctl2_r[rtc_pkg::C2_WFG] <= 1'b0;
                if (!wr_data[rtc_pkg::C2_DFG]) ctl2_r[rtc_pkg::C2_DFG] <= 1'b0;
            end
            if (s_halt_r[1]) ctl2_r[rtc_pkg::C2_HALT] <= 1'b1;
            if (s_low_r[1]) ctl2_r[rtc_pkg::C2_LOW] <= 1'b1;
            if (pfg_set || (!psel[2] && per_low)) ctl2_r[rtc_pkg::C2_PFG] <= 1'b1;
            else if (!psel[2]) ctl2_r[rtc_pkg::C2_PFG] <= 1'b0;
            if (wfg_set) ctl2_r[rtc_pkg::C2_WFG] <= 1'b1;
            if (dfg_set) ctl2_r[rtc_pkg::C2_DFG] <= 1'b1;
            if (ctl2_r[rtc_pkg::C2_PON]) begin
                ctl2_r[rtc_pkg::C2_SPA] <= 1'b0; // [R4]
                ctl2_r[rtc_pkg::C2_SPB] <= 1'b0;
                ctl2_r[rtc_pkg::C2_PFG] <= 1'b0;
                ctl2_r[rtc_pkg::C2_WFG] <= 1'b0;
                ctl2_r[rtc_pkg::C2_DFG] <= 1'b0;
            end
        end
    end

    always_comb begin
        unique case (psel) // [R15]
            rtc_pkg::P_LOW: per_low = 1'b1;
            rtc_pkg::P_2HZ: per_low = div_r < DIVW'(SEC_CYC / 4)
                                      || (!half && div_r < DIVW'(SEC_CYC * 3 / 4));
            rtc_pkg::P_1HZ: per_low = half;
            default: per_low = 1'b0;
        endcase
    end

    // Interrupt and power switches are registered outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= !((psel[2] ? ctl2_r[rtc_pkg::C2_PFG] : per_low)
                || ctl2_r[rtc_pkg::C2_WFG] || ctl2_r[rtc_pkg::C2_DFG]);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_path_switch <= 1'b0;
            backup_path_switch <= 1'b1;
        end else begin
            if (s_fall_r[1]) charge_path_switch <= 1'b0; // [R9]
            else if (s_rise_r[1]) charge_path_switch <= 1'b1;
            if (!ctl1_r[rtc_pkg::C1_BSW]) backup_path_switch <= 1'b1; // [R6] [R7]
            else if (s_fall_r[1]) backup_path_switch <= 1'b1; // [R8]
            else if (s_rise_r[1]) backup_path_switch <= 1'b0;
        end
    end
endmodule // rtc_core

// ==== test/rtc_core_assertions.sv ====
`timescale 1ns/1ps
module rtc_core_chk (
    // Clocks and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic ce,
    // Watched pins
    input wire logic serial_data_line_oe,
    input wire logic supply_above_rise,
    input wire logic supply_below_fall,
    input wire logic backup_path_switch,
    input wire logic charge_path_switch
);
    logic [4:0] edges_r;
    wire up = supply_above_rise && !supply_below_fall;
    wire dn = supply_below_fall && !supply_above_rise;
    wire mid = !supply_above_rise && !supply_below_fall;
    // Saturates so a long frame cannot wrap back to the start count
    always_ff @(posedge sclk or negedge ce) begin
        if (!ce) begin
            edges_r <= 5'h00;
        end else if (edges_r != 5'h1f) begin
            edges_r <= edges_r + 5'h01;
        end
    end
    sequence s_up; up [*4]; endsequence
    sequence s_dn; dn [*4]; endsequence
    a_chg_close: assert property (@(posedge clk) disable iff (!rst_n) s_up |=> charge_path_switch)
        else $error("charge path stayed open");
    a_chg_open: assert property (@(posedge clk) disable iff (!rst_n) s_dn |=> !charge_path_switch)
        else $error("charge path stayed closed");
    a_chg_hold: assert property (@(posedge clk) disable iff (!rst_n)
        mid [*5] |=> $stable(charge_path_switch))
        else $error("charge path moved between thresholds");
    a_bak_close: assert property (@(posedge clk) disable iff (!rst_n) s_dn |=> backup_path_switch)
        else $error("backup path open on low supply");
    a_bak_open: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(backup_path_switch) |-> !$past(supply_below_fall, 3)
        && $past(supply_above_rise, 3))
        else $error("backup path opened on low supply");
    a_oe_ce: assert property (@(posedge clk) disable iff (!rst_n) !ce |-> !serial_data_line_oe)
        else $error("data driven without chip enable");
    a_oe_hold: assert property (@(posedge clk) disable iff (!rst_n)
        serial_data_line_oe ##1 ce |-> serial_data_line_oe)
        else $error("read drive dropped inside frame");
    a_oe_start: assert property (@(negedge sclk) disable iff (!rst_n)
        $rose(serial_data_line_oe) |-> edges_r == 5'h11)
        else $error("read drive began at wrong link edge");
endmodule // rtc_core_chk
bind rtc_core rtc_core_chk u_chk (.clk, .rst_n, .sclk, .ce, .serial_data_line_oe,
    .supply_above_rise, .supply_below_fall, .backup_path_switch, .charge_path_switch);

// ==== test/rtc_host.sv ====
`timescale 1ns/1ps
// Link master; its clock runs only inside frames
module rtc_host (
    // Link pins
    output logic sclk,
    output logic ce,
    output logic sdl,
    // Device drive
    input wire logic oe,
    input wire logic dout
);
    logic hb;
    assign sdl = oe ? dout : hb;
    initial begin
        sclk = 1'b0;
        ce = 1'b0;
        hb = 1'b0;
    end
    // One register per frame, so auto-increment is never relied on
    task automatic xfer(input logic [3:0] a, input logic rd, input logic [7:0] wd,
        output logic [7:0] q);
        logic [15:0] s;
        s = {a, rd, 3'h0, wd};
        q = 8'h00;
        ce = 1'b1;
        #20;
        for (int i = 15; i >= 0; i--) begin
            hb = s[i];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        for (int i = 7; i >= 0 && rd; i--) begin
            hb = ~hb;
            #16 sclk = 1'b1;
            q[i] = sdl;
            #16 sclk = 1'b0;
        end
        #20 ce = 1'b0;
        hb = ~hb;
        #60;
    endtask
endmodule // rtc_host

// ==== test/tb_rtc_core.sv ====
`timescale 1ns/1ps
module tb_rtc_core;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ab = 1'b0, bf = 1'b0;
    wire sclk, ce, sdl, sdo, soe, bsw, csw, irq_n;
    int fails = 0;
    int cmp_count = 0;
    logic [7:0] wv [14] = '{8'hd9, 8'hd9, 8'hf2, 8'hfd, 8'he8, 8'hf2, 8'h96, 8'h85,
        8'hb0, 8'he5, 8'hff, 8'h80, 8'hd1, 8'ha5};
    logic [7:0] ev [14] = '{8'h59, 8'h59, 8'h32, 8'h05, 8'h28, 8'h12, 8'h96, 8'h85,
        8'h30, 8'h25, 8'h7f, 8'h00, 8'h11, 8'ha5};
    always #12.5 clk = ~clk;
    rtc_host u_host (.sclk(sclk), .ce(ce), .sdl(sdl), .oe(soe), .dout(sdo));
    rtc_core #(.SEC_CYC(60000)) u_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .ce(ce),
        .serial_data_line_in(sdl), .serial_data_line_out(sdo), .serial_data_line_oe(soe),
        .supply_above_rise(ab), .supply_below_fall(bf), .osc_halt_det(1'b0),
        .low_supply_det(1'b0), .backup_path_switch(bsw), .charge_path_switch(csw),
        .interrupt_out_n(irq_n));
    task automatic conclude();
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] z;
        @(negedge clk);
        u_host.xfer(a, 1'b0, d, z);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] z;
        @(negedge clk);
        u_host.xfer(a, 1'b1, 8'h00, z);
        chk(z, e);
    endtask
    // Pins packed as {interrupt, charge, backup}
    task automatic pins(input logic [7:0] e);
        repeat (8) @(negedge clk);
        chk({5'h00, irq_n, csw, bsw}, e);
    endtask
    initial begin
        // The 2 Hz check alone waits half a millisecond
        #1000000;
        fails++;
        conclude();
    end
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(rtc_pkg::A_TRIM, 8'h00);
        rd(rtc_pkg::A_USER, 8'h00);
        rd(rtc_pkg::A_CTL1, 8'h00);
        rd(rtc_pkg::A_CTL2, 8'h70);
        wr(rtc_pkg::A_CTL1, 8'h10);
        rd(rtc_pkg::A_CTL1, 8'h00);
        wr(rtc_pkg::A_TRIM, 8'h85);
        rd(rtc_pkg::A_TRIM, 8'h00);
        wr(rtc_pkg::A_CTL2, 8'hff);
        rd(rtc_pkg::A_CTL2, 8'h70);
        wr(rtc_pkg::A_CTL2, 8'h00);
        rd(rtc_pkg::A_CTL2, 8'h00);
        wr(rtc_pkg::A_CTL2, 8'h10);
        rd(rtc_pkg::A_CTL2, 8'h00);
        wr(rtc_pkg::A_CTL1, 8'h00);
        for (int i = 0; i < 14; i++) begin
            wr(4'(i), wv[i]);
            rd(4'(i), ev[i]);
        end
        ab = 1'b1;
        pins(8'h07);
        wr(rtc_pkg::A_CTL1, 8'hd0);
        rd(rtc_pkg::A_CTL1, 8'hd0);
        pins(8'h06);
        ab = 1'b0;
        bf = 1'b1;
        pins(8'h05);
        bf = 1'b0;
        ab = 1'b1;
        pins(8'h06);
        // Seconds write restarts the divider: 2 Hz is low, then high in quarter two
        wr(rtc_pkg::A_SEC, 8'h00);
        wr(rtc_pkg::A_CTL1, 8'h02);
        pins(8'h03);
        repeat (20000) @(negedge clk);
        pins(8'h07);
        wr(rtc_pkg::A_CTL1, 8'h03);
        pins(8'h03);
        wr(rtc_pkg::A_CTL1, 8'h01);
        pins(8'h03);
        wr(rtc_pkg::A_CTL1, 8'h00);
        pins(8'h07);
        conclude();
    end
endmodule // tb_rtc_core
